// file: bench/reclocker_control_registers_tb.sv
`timescale 1ns/1ps
module reclocker_control_registers_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cdrLock = 1'b0;
  logic sclPin, sdaPin, sdaOut, sdaOe;
  logic autoRateDetectOn, outputInhibitN, skipRate177, autoBypass, lossDetectDisable, bypassNow;
  logic [1:0] rateSearchOrder, inputSelect, refClockMode, outputSwing, outputBufferType;
  logic [2:0] manualRate, lossThreshold, activeRate, detectedRateCode;
  int fail_count = 0;
  int comparisons = 0;
  logic [7:0] addrs [5] = '{8'h06, 8'h07, 8'h08, 8'h0a, 8'h0e};
  logic [7:0] rsts [5] = '{8'h3d, 8'h74, 8'h35, 8'h3c, 8'h40};
  logic [7:0] masks [5] = '{8'h3f, 8'h1f, 8'h30, 8'h0f, 8'h17};
  logic [1:0] ords [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
  logic [7:0] ios [5] = '{8'h7c, 8'h7c, 8'h7c, 8'h7c, 8'h74};
  logic [2:0] secs [5] = '{3'h5, 3'h3, 3'h3, 3'h2, 3'h1};

  always #12.5 mclk = ~mclk;

  reclocker_control_registers uut (.mclk(mclk), .reset(reset), .sclIn(sclPin),
    .sdaIn(sdaPin), .cdrLock(cdrLock), .sdaOut(sdaOut), .sdaOe(sdaOe),
    .autoRateDetectOn(autoRateDetectOn), .rateSearchOrder(rateSearchOrder),
    .manualRate(manualRate), .outputInhibitN(outputInhibitN), .skipRate177(skipRate177),
    .autoBypass(autoBypass), .inputSelect(inputSelect), .refClockMode(refClockMode),
    .outputSwing(outputSwing), .outputBufferType(outputBufferType),
    .lossDetectDisable(lossDetectDisable), .lossThreshold(lossThreshold),
    .activeRate(activeRate), .bypassNow(bypassNow), .detectedRateCode(detectedRateCode));

  reclocker_host host (.mclk(mclk), .sdaOut(sdaOut), .sdaOe(sdaOe), .sclPin(sclPin),
    .sdaPin(sdaPin));

  // ==========================================================
  // helpers
  // ==========================================================
  function automatic logic [7:0] view(input int i);
    case (i)
      0: return {2'b00, autoRateDetectOn, rateSearchOrder, manualRate};
      1: return {3'b000, outputInhibitN, skipRate177, autoBypass, inputSelect};
      2: return {2'b00, refClockMode, 4'h0};
      3: return {4'h0, outputSwing, outputBufferType};
      default: return {3'b000, lossDetectDisable, 1'b0, lossThreshold};
    endcase
  endfunction

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic ok;
    host.wrReg(a, d, ok);
    cmp({7'h0, ok}, 8'h01);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic ok;
    host.rdReg(a, d, ok);
    cmp({7'h0, ok}, 8'h01);
    cmp(d, exp);
  endtask

  task automatic chk(input int i, input logic [7:0] v);
    rd(addrs[i], v);
    cmp(view(i), v & masks[i]);
  endtask

  task automatic wrchk(input int i, input logic [7:0] v);
    wr(addrs[i], v);
    chk(i, v);
  endtask

  task automatic softrst;
    wr(8'h03, 8'h07);
    wr(8'h03, 8'h87);
  endtask

  task end_sim;
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge mclk);
    fail_count++;
    end_sim;
  end

  // ==========================================================
  // tests
  // ==========================================================
  initial begin
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    repeat (8) @(negedge mclk);
    for (int i = 0; i < 5; i++) chk(i, rsts[i]);
    cmp({5'h0, detectedRateCode}, 8'h07);
    for (int k = 0; k < 8; k++) begin
      wrchk(0, {5'b00011, 3'(k)});
      cmp({5'h0, activeRate}, 8'(k));
      cmp({5'h0, detectedRateCode}, 8'h06);
    end
    for (int k = 0; k < 4; k++) begin
      wrchk(1, {3'b011, k[1], k[0], ~k[0], 2'(k)});
      wrchk(2, {2'b00, 2'(k), 4'b0101});
      wrchk(3, {4'b0010, 2'(k), 2'b00});
    end
    for (int k = 0; k < 6; k++) wrchk(4, {3'b010, k[0], 1'b0, 3'(k)});
    wr(8'h0b, 8'h5a);
    rd(8'h0b, 8'h00);
    wr(8'h14, 8'hff);
    rd(8'h14, 8'h60);
    chk(0, 8'h1f);
    for (int s = 0; s < 5; s++) begin
      wr(8'h07, ios[s]);
      wr(8'h06, {3'b001, ords[s], 3'b101});
      softrst;
      cmp({5'h0, activeRate}, (ords[s] == 2'h3) ? 8'h00 : 8'h02);
      cmp({5'h0, detectedRateCode}, 8'h07);
      cmp({7'h0, bypassNow}, 8'h01);
      repeat (4000) @(negedge mclk);
      cmp({5'h0, activeRate}, {5'h0, secs[s]});
    end
    cdrLock = 1'b1;
    repeat (10) @(negedge mclk);
    cmp({5'h0, detectedRateCode}, 8'h01);
    cmp({7'h0, bypassNow}, 8'h00);
    repeat (4000) @(negedge mclk);
    cmp({5'h0, activeRate}, 8'h01);
    cdrLock = 1'b0;
    repeat (10) @(negedge mclk);
    cmp({7'h0, bypassNow}, 8'h01);
    wrchk(1, 8'h70);
    cmp({7'h0, bypassNow}, 8'h00);
    end_sim;
  end
endmodule

// file: bench/reclocker_host.sv
`timescale 1ns/1ps
// ==========================================================
// two-wire bus host
// ==========================================================
module reclocker_host (
  input wire logic mclk,
  input wire logic sdaOut,
  input wire logic sdaOe,
  output logic sclPin,
  output logic sdaPin
);
  logic sclLow = 1'b0;
  logic sdaLow = 1'b0;

  // open drain lines with pull-ups
  assign sclPin = ~sclLow;
  assign sdaPin = ~(sdaLow | (sdaOe & ~sdaOut));

  task automatic waitn(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // one clock pulse, data moved well clear of the scl fall
  task automatic bitx(input logic b, output logic r);
    waitn(1);
    sclLow = 1'b1;
    waitn(2);
    sdaLow = ~b;
    waitn(8);
    sclLow = 1'b0;
    waitn(9);
    r = sdaPin;
  endtask

  // start (or repeated start) when stop is 0, stop when 1
  task automatic cond(input logic stop);
    logic r;
    bitx(~stop, r);
    sdaLow = ~stop;
    waitn(9);
  endtask

  task automatic xfer(input logic [7:0] d, input logic ackIn, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
    bitx(ackIn, ack);
  endtask

  task automatic wrReg(input logic [7:0] a, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2;
    cond(1'b0);
    xfer({reclocker_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    xfer(d, 1'b1, q, k2);
    cond(1'b1);
    ok = ~(k0 | k1 | k2);
  endtask

  // single byte read, ended by a no-acknowledge
  task automatic rdReg(input logic [7:0] a, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic k0, k1, k2, k3;
    cond(1'b0);
    xfer({reclocker_pkg::DEVICE_ADDR, 1'b0}, 1'b1, q, k0);
    xfer(a, 1'b1, q, k1);
    cond(1'b0);
    xfer({reclocker_pkg::DEVICE_ADDR, 1'b1}, 1'b1, q, k2);
    xfer(8'hff, 1'b1, d, k3);
    cond(1'b1);
    ok = ~(k0 | k1 | k2);
  endtask
endmodule

// file: core/reclocker_control_registers.sv
`timescale 1ns/1ps
// Operation
// - bit 5 of rate register enables automatic rate detection, reset 1
// - bits 4:3 choose the repeating automatic search order, reset 11
// - with automatic detection off, bits 2:0 force the rate, reset 101
// - io register bit 4, reset 1: 0 holds data outputs low
// - io register bit 3, reset 0: 1 drops 177 Mb/s from search
// - io register bit 2, reset 1: bypass retiming while out of lock
// - io register bits 1:0, reset 00, pick one of four inputs
// - clock register bits 5:4, reset 11, choose reference clock source
// - driver register bits 3:2, reset 11, set output swing
// - driver register bits 1:0, reset 00 selects CML; others reserved
// - loss register bit 4, reset 0: 1 disables signal-loss detection
// - loss register bits 2:0, reset 000, choose threshold; 110/111 unused
// - in automatic mode report detected rate; 110 invalid, 111 unlocked
module reclocker_control_registers (
  input wire logic mclk,
  input wire logic reset,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic cdrLock,
  output logic sdaOut,
  output logic sdaOe,
  output logic autoRateDetectOn,
  output logic [1:0] rateSearchOrder,
  output logic [2:0] manualRate,
  output logic outputInhibitN,
  output logic skipRate177,
  output logic autoBypass,
  output logic [1:0] inputSelect,
  output logic [1:0] refClockMode,
  output logic [1:0] outputSwing,
  output logic [1:0] outputBufferType,
  output logic lossDetectDisable,
  output logic [2:0] lossThreshold,
  output logic [2:0] activeRate,
  output logic bypassNow,
  output logic [2:0] detectedRateCode
);

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  logic [2:0] pins;
  logic [2:0] stage1_r, stage1_nxt, stage2_r, stage2_nxt, stage3_r, stage3_nxt;
  logic [2:0] filt_r, filt_nxt, prev_r, prev_nxt;
  logic sclRise, sclFall, startCond, stopCond, sdaLvl, lockLvl;

  assign pins = {cdrLock, sdaIn, sclIn};

  always_comb begin
    stage1_nxt = pins;
    stage2_nxt = stage1_r;
    stage3_nxt = stage2_r;
    prev_nxt = filt_r;
    for (int i = 0; i < 3; i++) begin
      filt_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i] : filt_r[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      stage1_r <= 3'h3;
      stage2_r <= 3'h3;
      stage3_r <= 3'h3;
      filt_r <= 3'h3;
      prev_r <= 3'h3;
    end else begin
      stage1_r <= stage1_nxt;
      stage2_r <= stage2_nxt;
      stage3_r <= stage3_nxt;
      filt_r <= filt_nxt;
      prev_r <= prev_nxt;
    end
  end

  assign sdaLvl = filt_r[reclocker_pkg::PIN_SDA];
  assign lockLvl = filt_r[reclocker_pkg::PIN_LOCK];
  assign sclRise = filt_r[reclocker_pkg::PIN_SCL] & ~prev_r[reclocker_pkg::PIN_SCL];
  assign sclFall = ~filt_r[reclocker_pkg::PIN_SCL] & prev_r[reclocker_pkg::PIN_SCL];
  assign startCond = filt_r[reclocker_pkg::PIN_SCL] & prev_r[reclocker_pkg::PIN_SCL]
                     & prev_r[reclocker_pkg::PIN_SDA] & ~sdaLvl;
  assign stopCond = filt_r[reclocker_pkg::PIN_SCL] & prev_r[reclocker_pkg::PIN_SCL]
                    & ~prev_r[reclocker_pkg::PIN_SDA] & sdaLvl;

  // ==========================================================
  // register storage and read decode
  // ==========================================================
  logic [reclocker_pkg::NUM_REGS-1:0][7:0] ctrl_r, ctrl_nxt;
  logic [7:0] ptr_r, ptr_nxt, shift_r, shift_nxt, rdByte;
  logic wrEn;

  function automatic logic [7:0] readReg(
    input logic [7:0] a,
    input logic [reclocker_pkg::NUM_REGS-1:0][7:0] c,
    input logic [2:0] ind
  );
    logic [7:0] d;
    d = 8'h00;
    for (int i = 0; i < reclocker_pkg::NUM_REGS; i++) begin
      if (a == reclocker_pkg::REG_ADDRS[i]) begin
        d = c[i];
      end
    end
    if (a == reclocker_pkg::ADDR_RATE_IND) begin
      d[reclocker_pkg::RATE_IND_LSB +: 3] = ind;
    end
    return d;
  endfunction

  always_comb begin
    for (int i = 0; i < reclocker_pkg::NUM_REGS; i++) begin
      ctrl_nxt[i] = (wrEn && ptr_r == reclocker_pkg::REG_ADDRS[i]) ? shift_r : ctrl_r[i];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_r <= reclocker_pkg::REG_RESETS;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  assign autoRateDetectOn = ctrl_r[reclocker_pkg::IDX_RATE][reclocker_pkg::AUTO_ON_BIT];
  assign rateSearchOrder = ctrl_r[reclocker_pkg::IDX_RATE][reclocker_pkg::ORDER_LSB +: 2];
  assign manualRate = ctrl_r[reclocker_pkg::IDX_RATE][reclocker_pkg::MANUAL_LSB +: 3];
  assign outputInhibitN = ctrl_r[reclocker_pkg::IDX_IO][reclocker_pkg::INHIBIT_BIT];
  assign skipRate177 = ctrl_r[reclocker_pkg::IDX_IO][reclocker_pkg::SKIP_BIT];
  assign autoBypass = ctrl_r[reclocker_pkg::IDX_IO][reclocker_pkg::BYPASS_BIT];
  assign inputSelect = ctrl_r[reclocker_pkg::IDX_IO][reclocker_pkg::INSEL_LSB +: 2];
  assign refClockMode = ctrl_r[reclocker_pkg::IDX_REFCLK][reclocker_pkg::REFMODE_LSB +: 2];
  assign outputSwing = ctrl_r[reclocker_pkg::IDX_DRIVER][reclocker_pkg::SWING_LSB +: 2];
  assign outputBufferType = ctrl_r[reclocker_pkg::IDX_DRIVER][reclocker_pkg::BUFTYPE_LSB +: 2];
  assign lossDetectDisable = ctrl_r[reclocker_pkg::IDX_LOSS][reclocker_pkg::LOSS_DIS_BIT];
  assign lossThreshold = ctrl_r[reclocker_pkg::IDX_LOSS][reclocker_pkg::THRESH_LSB +: 3];

  assign rdByte = readReg(ptr_r, ctrl_r, detectedRateCode);

  // ==========================================================
  // two-wire slave
  // ==========================================================
  reclocker_pkg::serial_state_t state_r, state_nxt;
  logic [3:0] bitCnt_r, bitCnt_nxt;
  logic rw_r, rw_nxt, ackd_r, ackd_nxt, sdaOe_r, sdaOe_nxt, sdaOut_r;

  always_comb begin
    state_nxt = state_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    ackd_nxt = ackd_r;
    sdaOe_nxt = sdaOe_r;
    wrEn = 1'b0;
    if (startCond) begin
      state_nxt = reclocker_pkg::ST_ADDR;
      bitCnt_nxt = 4'h0;
      sdaOe_nxt = 1'b0;
    end else if (stopCond) begin
      state_nxt = reclocker_pkg::ST_IDLE;
      sdaOe_nxt = 1'b0;
    end else if (sclRise) begin
      if (state_r inside {reclocker_pkg::ST_ADDR, reclocker_pkg::ST_PTR,
                          reclocker_pkg::ST_WRITE}) begin
        shift_nxt = {shift_r[6:0], sdaLvl};
        bitCnt_nxt = bitCnt_r + 4'h1;
      end
      if (state_r == reclocker_pkg::ST_READ_ACK) begin
        ackd_nxt = ~sdaLvl;
      end
    end else if (sclFall) begin
      unique case (state_r)
        reclocker_pkg::ST_IDLE: begin
        end
        reclocker_pkg::ST_ADDR: begin
          if (bitCnt_r == reclocker_pkg::BITS_PER_BYTE) begin
            if (shift_r[7:1] == reclocker_pkg::DEVICE_ADDR) begin
              state_nxt = reclocker_pkg::ST_ADDR_ACK;
              rw_nxt = shift_r[0];
              sdaOe_nxt = 1'b1;
            end else begin
              state_nxt = reclocker_pkg::ST_IDLE;
            end
          end
        end
        reclocker_pkg::ST_ADDR_ACK, reclocker_pkg::ST_READ_ACK: begin
          bitCnt_nxt = 4'h0;
          if (state_r == reclocker_pkg::ST_READ_ACK && !ackd_r) begin
            state_nxt = reclocker_pkg::ST_IDLE;
            sdaOe_nxt = 1'b0;
          end else if (rw_r) begin
            state_nxt = reclocker_pkg::ST_READ;
            shift_nxt = rdByte;
            ptr_nxt = ptr_r + 8'h01;
            sdaOe_nxt = ~rdByte[7];
          end else begin
            state_nxt = reclocker_pkg::ST_PTR;
            sdaOe_nxt = 1'b0;
          end
        end
        reclocker_pkg::ST_PTR: begin
          if (bitCnt_r == reclocker_pkg::BITS_PER_BYTE) begin
            state_nxt = reclocker_pkg::ST_PTR_ACK;
            ptr_nxt = shift_r;
            sdaOe_nxt = 1'b1;
          end
        end
        reclocker_pkg::ST_PTR_ACK, reclocker_pkg::ST_WRITE_ACK: begin
          state_nxt = reclocker_pkg::ST_WRITE;
          bitCnt_nxt = 4'h0;
          sdaOe_nxt = 1'b0;
        end
        reclocker_pkg::ST_WRITE: begin
          if (bitCnt_r == reclocker_pkg::BITS_PER_BYTE) begin
            state_nxt = reclocker_pkg::ST_WRITE_ACK;
            wrEn = 1'b1;
            ptr_nxt = ptr_r + 8'h01;
            sdaOe_nxt = 1'b1;
          end
        end
        reclocker_pkg::ST_READ: begin
          if (bitCnt_r == reclocker_pkg::LAST_READ_BIT) begin
            state_nxt = reclocker_pkg::ST_READ_ACK;
            sdaOe_nxt = 1'b0;
          end else begin
            shift_nxt = {shift_r[6:0], 1'b0};
            sdaOe_nxt = ~shift_r[6];
            bitCnt_nxt = bitCnt_r + 4'h1;
          end
        end
        default: begin
          state_nxt = reclocker_pkg::ST_IDLE;
          sdaOe_nxt = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= reclocker_pkg::ST_IDLE;
      bitCnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      ackd_r <= 1'b0;
      sdaOe_r <= 1'b0;
      sdaOut_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      ackd_r <= ackd_nxt;
      sdaOe_r <= sdaOe_nxt;
      sdaOut_r <= 1'b0;
    end
  end

  assign sdaOe = sdaOe_r;
  assign sdaOut = sdaOut_r;

  // ==========================================================
  // rate search and status
  // ==========================================================
  logic [2:0] searchRate_r, searchRate_nxt, activeRate_r, activeRate_nxt;
  logic [2:0] detected_r, detected_nxt;
  logic [11:0] dwell_r, dwell_nxt;
  logic restart_r, restart_nxt, bypassNow_r, bypassNow_nxt;

  function automatic logic [2:0] nextRate(
    input logic [1:0] order,
    input logic [2:0] cur,
    input logic skip
  );
    logic [2:0] n;
    n = reclocker_pkg::RATE_270;
    unique case (cur)
      reclocker_pkg::RATE_143: n = skip ? reclocker_pkg::RATE_270 : reclocker_pkg::RATE_177;
      reclocker_pkg::RATE_177: n = reclocker_pkg::RATE_270;
      reclocker_pkg::RATE_270: n = (order == reclocker_pkg::ORDER_TWO) ?
                                   reclocker_pkg::RATE_1485 : reclocker_pkg::RATE_360;
      reclocker_pkg::RATE_360: n = (order == reclocker_pkg::ORDER_THREE) ?
                                   reclocker_pkg::RATE_1485 : reclocker_pkg::RATE_540;
      reclocker_pkg::RATE_540: n = reclocker_pkg::RATE_1485;
      default: n = (order == reclocker_pkg::ORDER_SIX) ?
                   reclocker_pkg::RATE_143 : reclocker_pkg::RATE_270;
    endcase
    return n;
  endfunction

  always_comb begin
    restart_nxt = wrEn && (ptr_r == reclocker_pkg::ADDR_RATE || ptr_r == reclocker_pkg::ADDR_IO);
    searchRate_nxt = searchRate_r;
    dwell_nxt = dwell_r;
    if (restart_r || !autoRateDetectOn) begin
      searchRate_nxt = (rateSearchOrder == reclocker_pkg::ORDER_SIX) ?
                       reclocker_pkg::RATE_143 : reclocker_pkg::RATE_270;
      dwell_nxt = 12'h000;
    end else if (lockLvl) begin
      dwell_nxt = 12'h000;
    end else if (dwell_r == reclocker_pkg::DWELL_LAST) begin
      dwell_nxt = 12'h000;
      searchRate_nxt = nextRate(rateSearchOrder, searchRate_r, skipRate177);
    end else begin
      dwell_nxt = dwell_r + 12'h001;
    end
    activeRate_nxt = autoRateDetectOn ? searchRate_r : manualRate;
    bypassNow_nxt = autoBypass & ~lockLvl;
    if (!autoRateDetectOn) begin
      detected_nxt = reclocker_pkg::IND_INVALID;
    end else if (!lockLvl) begin
      detected_nxt = reclocker_pkg::IND_NOT_LOCKED;
    end else begin
      detected_nxt = searchRate_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      searchRate_r <= reclocker_pkg::RATE_143;
      dwell_r <= 12'h000;
      restart_r <= 1'b1;
      activeRate_r <= reclocker_pkg::RATE_1485;
      detected_r <= reclocker_pkg::IND_NOT_LOCKED;
      bypassNow_r <= 1'b0;
    end else begin
      searchRate_r <= searchRate_nxt;
      dwell_r <= dwell_nxt;
      restart_r <= restart_nxt;
      activeRate_r <= activeRate_nxt;
      detected_r <= detected_nxt;
      bypassNow_r <= bypassNow_nxt;
    end
  end

  assign activeRate = activeRate_r;
  assign detectedRateCode = detected_r;
  assign bypassNow = bypassNow_r;

  // ==========================================================
  // checks
  // ==========================================================
  AST_RESET_DEFAULTS: assert property (@(posedge mclk)
    reset |=> ctrl_r == reclocker_pkg::REG_RESETS)
    else $error("registers not at defaults after reset");
  AST_AUTO_ON_WRITE: assert property (@(posedge mclk) disable iff (reset)
    wrEn && ptr_r == reclocker_pkg::ADDR_RATE
    |=> autoRateDetectOn == $past(shift_r[reclocker_pkg::AUTO_ON_BIT]))
    else $error("auto detect bit did not take written value");
  AST_ORDER_TWO_STEP: assert property (@(posedge mclk) disable iff (reset)
    autoRateDetectOn && !lockLvl && !restart_r && rateSearchOrder == reclocker_pkg::ORDER_TWO
    && searchRate_r == reclocker_pkg::RATE_270 && dwell_r == reclocker_pkg::DWELL_LAST
    |=> searchRate_r == reclocker_pkg::RATE_1485)
    else $error("search order 00 did not go from 270 to 1485");
  AST_MANUAL_FORCE: assert property (@(posedge mclk) disable iff (reset)
    !autoRateDetectOn ##1 !autoRateDetectOn |-> activeRate == $past(manualRate))
    else $error("manual rate not applied");
  AST_SKIP_177: assert property (@(posedge mclk) disable iff (reset)
    skipRate177 && !restart_r && autoRateDetectOn |-> searchRate_r != reclocker_pkg::RATE_177)
    else $error("search visited 177 while skipped");
  AST_BYPASS_UNLOCKED: assert property (@(posedge mclk) disable iff (reset)
    autoBypass && !lockLvl |=> bypassNow)
    else $error("no bypass while out of lock");
  AST_INPUT_SELECT: assert property (@(posedge mclk) disable iff (reset)
    wrEn && ptr_r == reclocker_pkg::ADDR_IO
    |=> inputSelect == $past(shift_r[reclocker_pkg::INSEL_LSB +: 2]))
    else $error("input select did not take written value");
  AST_NOT_LOCKED_CODE: assert property (@(posedge mclk) disable iff (reset)
    autoRateDetectOn && !lockLvl |=> detectedRateCode == reclocker_pkg::IND_NOT_LOCKED)
    else $error("unlocked state not reported as 111");

endmodule

// file: core/reclocker_pkg.sv
package reclocker_pkg;

  // ==========================================================
  // serial port
  // ==========================================================
  localparam logic [6:0] DEVICE_ADDR = 7'h2c; // arbitrary value
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_READ_BIT = 4'h7;
  localparam int PIN_SCL = 0;
  localparam int PIN_SDA = 1;
  localparam int PIN_LOCK = 2;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_ADDR = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_PTR = 4'h3,
    ST_PTR_ACK = 4'h4,
    ST_WRITE = 4'h5,
    ST_WRITE_ACK = 4'h6,
    ST_READ = 4'h7,
    ST_READ_ACK = 4'h8
  } serial_state_t;

  // ==========================================================
  // register map
  // ==========================================================
  localparam int NUM_REGS = 5;
  localparam logic [7:0] ADDR_RATE = 8'h06;
  localparam logic [7:0] ADDR_IO = 8'h07;
  localparam logic [7:0] ADDR_REFCLK = 8'h08;
  localparam logic [7:0] ADDR_DRIVER = 8'h0a;
  localparam logic [7:0] ADDR_LOSS = 8'h0e;
  localparam logic [7:0] ADDR_RATE_IND = 8'h14;
  localparam logic [7:0] RST_RATE = 8'h3d;
  localparam logic [7:0] RST_IO = 8'h74;
  localparam logic [7:0] RST_REFCLK = 8'h35;
  localparam logic [7:0] RST_DRIVER = 8'h3c;
  localparam logic [7:0] RST_LOSS = 8'h40;
  localparam logic [NUM_REGS-1:0][7:0] REG_ADDRS =
    {ADDR_LOSS, ADDR_DRIVER, ADDR_REFCLK, ADDR_IO, ADDR_RATE};
  localparam logic [NUM_REGS-1:0][7:0] REG_RESETS =
    {RST_LOSS, RST_DRIVER, RST_REFCLK, RST_IO, RST_RATE};
  localparam int IDX_RATE = 0;
  localparam int IDX_IO = 1;
  localparam int IDX_REFCLK = 2;
  localparam int IDX_DRIVER = 3;
  localparam int IDX_LOSS = 4;

  // ==========================================================
  // field positions
  // ==========================================================
  localparam int AUTO_ON_BIT = 5;
  localparam int ORDER_LSB = 3;
  localparam int MANUAL_LSB = 0;
  localparam int INHIBIT_BIT = 4;
  localparam int SKIP_BIT = 3;
  localparam int BYPASS_BIT = 2;
  localparam int INSEL_LSB = 0;
  localparam int REFMODE_LSB = 4;
  localparam int SWING_LSB = 2;
  localparam int BUFTYPE_LSB = 0;
  localparam int LOSS_DIS_BIT = 4;
  localparam int THRESH_LSB = 0;
  localparam int RATE_IND_LSB = 4;

  // ==========================================================
  // rate codes and search
  // ==========================================================
  localparam logic [2:0] RATE_143 = 3'h0;
  localparam logic [2:0] RATE_177 = 3'h1;
  localparam logic [2:0] RATE_270 = 3'h2;
  localparam logic [2:0] RATE_360 = 3'h3;
  localparam logic [2:0] RATE_540 = 3'h4;
  localparam logic [2:0] RATE_1485 = 3'h5;
  localparam logic [2:0] IND_INVALID = 3'h6;
  localparam logic [2:0] IND_NOT_LOCKED = 3'h7;
  localparam logic [1:0] ORDER_TWO = 2'h0;
  localparam logic [1:0] ORDER_THREE = 2'h1;
  localparam logic [1:0] ORDER_SIX = 2'h3;
  localparam int CLK_PERIOD_NS = 25;
  localparam int DWELL_NS = 100000;
  localparam int DWELL_CYCLES = DWELL_NS / CLK_PERIOD_NS;
  localparam logic [11:0] DWELL_LAST = 12'(DWELL_CYCLES - 1);

endpackage
